// ---- hdl/vrb_regs.svh ----
`ifndef VRB_REGS_SVH
`define VRB_REGS_SVH
`define VRB_ADDR_FAST_SLEW 8'h24
`define VRB_ADDR_SLOW_SLEW 8'h25
`define VRB_ADDR_BOOT_VOLTAGE 8'h26
`define VRB_ADDR_SLOW_DIV_SEL 8'h2a
`define VRB_ADDR_DEEP_EXIT_LAT 8'h2b
`define VRB_ADDR_LIGHT_EXIT_LAT 8'h2c
`define VRB_ADDR_EN_READY_LAT 8'h2d
`define VRB_ADDR_PIN_MAX 8'h2e
`define VRB_ADDR_INPUT_POWER_ALERT_THRESHOLD 8'h2f
`define VRB_ADDR_MAX_VID 8'h30
`define VRB_ADDR_VID 8'h31
`define VRB_ADDR_POWER_STATE 8'h32
`define VRB_ADDR_MARGIN 8'h33
`define VRB_ADDR_MULTI_CFG 8'h34
`define VRB_ADDR_WRITE_PTR 8'h35
`define VRB_ADDR_P1_VID 8'h42
`define VRB_ADDR_P1_CUR 8'h43
`define VRB_ADDR_P2_VID 8'h44
`define VRB_ADDR_P2_CUR 8'h45
`define VRB_ADDR_P3_VID 8'h46
`define VRB_ADDR_P3_CUR 8'h47
`define VRB_RST_SLOW_DIV_SEL 8'h01
`define VRB_RST_MAX_VID 8'hfb
`define VRB_RST_POWER_STATE 8'h00
`define VRB_RST_MARGIN 8'h00
`define VRB_RST_MULTI_CFG 8'h00
`define VRB_RST_WRITE_PTR 8'h35
`define VRB_RST_LIMIT 8'h00
`define VRB_VAL_DEEP_EXIT_LAT 8'h8c
`define VRB_VAL_LIGHT_EXIT_LAT 8'h55
`define VRB_VAL_EN_READY_LAT 8'hca
`define VRB_FAST_SLEW_LOW 8'h0a
`define VRB_FAST_SLEW_HIGH 8'h1e
`define VRB_DIV_SEL_MIN 8'h01
`define VRB_DIV_SEL_MAX 8'h04
`define VRB_MULTI_CFG_READY_ON_ZERO 0
`define VRB_MARGIN_SIGN 7
`define VRB_CLK_MHZ 25
`define VRB_EN_READY_US 202
`endif

// ---- hdl/vrb_pkg.sv ----
`default_nettype none
package vrb_pkg;
  typedef enum logic [2:0] {
    VRB_CMD_FAST_VID = 3'b000,
    VRB_CMD_SLOW_VID = 3'b001,
    VRB_CMD_SET_PS = 3'b010,
    VRB_CMD_GET_REG = 3'b011,
    VRB_CMD_SET_ADDR = 3'b100,
    VRB_CMD_SET_DATA = 3'b101
  } vrb_cmd_e;
  typedef enum logic [1:0] {
    VRB_ACK_OK = 2'b00,
    VRB_ACK_NOT_SUPPORTED = 2'b01,
    VRB_ACK_REJECT = 2'b10
  } vrb_ack_e;
  typedef enum logic [1:0] {
    VRB_ST_WAIT_EN = 2'b00,
    VRB_ST_COUNT = 2'b01,
    VRB_ST_READY = 2'b10
  } vrb_state_e;
  typedef logic [7:0] vrb_byte_t;
endpackage
`default_nettype wire

// ---- hdl/vrb_register_bank.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "vrb_regs.svh"
module vrb_register_bank #(
  parameter int READY_CYCLES = `VRB_EN_READY_US * `VRB_CLK_MHZ
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic enable_pin,
  input wire logic fast_rate_strap,
  input wire vrb_pkg::vrb_byte_t boot_vid_strap,
  input wire vrb_pkg::vrb_byte_t pin_max_value,
  input wire vrb_pkg::vrb_byte_t pin_alert_value,
  input wire logic cmd_valid,
  input wire vrb_pkg::vrb_cmd_e cmd_type,
  input wire vrb_pkg::vrb_byte_t cmd_addr,
  input wire vrb_pkg::vrb_byte_t cmd_data,
  output logic resp_valid,
  output vrb_pkg::vrb_ack_e resp_ack,
  output vrb_pkg::vrb_byte_t resp_data,
  output logic regulator_ready_flag,
  output vrb_pkg::vrb_byte_t target_vid,
  output vrb_pkg::vrb_byte_t ramp_slew,
  output vrb_pkg::vrb_byte_t current_limit,
  output vrb_pkg::vrb_byte_t power_state_out
);
  import vrb_pkg::*;

  localparam int CNT_W = 16;

  logic en_s1;
  logic en_s2;
  logic en_s3;
  logic en_level;
  vrb_state_e state;
  logic [CNT_W-1:0] ready_cnt;
  logic boot_taken;
  logic vid_commanded;
  vrb_byte_t fast_slew_rate;
  vrb_byte_t boot_voltage;
  vrb_byte_t slow_rate_divider_select;
  vrb_byte_t max_vid_limit;
  vrb_byte_t current_vid_code;
  vrb_byte_t power_state_setting;
  vrb_byte_t vid_margin_steps;
  vrb_byte_t multi_regulator_config;
  vrb_byte_t register_write_pointer;
  vrb_byte_t limit_point1_vid;
  vrb_byte_t limit_point1_current;
  vrb_byte_t limit_point2_vid;
  vrb_byte_t limit_point2_current;
  vrb_byte_t limit_point3_vid;
  vrb_byte_t limit_point3_current;
  logic slow_selected;

  // Enable comes from a pin: three flops, level changes once the last two agree.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      en_s3 <= 1'b0;
      en_level <= 1'b0;
    end else if (ce) begin
      en_s1 <= enable_pin;
      en_s2 <= en_s1;
      en_s3 <= en_s2;
      if (en_s2 == en_s3) begin
        en_level <= en_s3;
      end
    end
  end

  wire ready = (state == VRB_ST_READY);
  wire taken = ce && cmd_valid;
  wire accepted = taken && ready;
  wire is_vid_cmd = (cmd_type == VRB_CMD_FAST_VID) || (cmd_type == VRB_CMD_SLOW_VID);
  wire vid_too_high = cmd_data > max_vid_limit;
  wire vid_ok = accepted && is_vid_cmd && !vid_too_high;
  wire zero_drop = vid_ok && (cmd_data == 8'h00) &&
                   multi_regulator_config[`VRB_MULTI_CFG_READY_ON_ZERO];
  wire wr_en = accepted && (cmd_type == VRB_CMD_SET_DATA);
  wire ptr_wr = accepted && (cmd_type == VRB_CMD_SET_ADDR);
  wire vbyte_w = wr_en && (register_write_pointer == `VRB_ADDR_VID);
  wire div_sel_legal = (cmd_data >= `VRB_DIV_SEL_MIN) && (cmd_data <= `VRB_DIV_SEL_MAX);

  // The ready counter clears when enable drops so a glitch cannot finish it early.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= VRB_ST_WAIT_EN;
      ready_cnt <= '0;
    end else if (ce) begin
      case (state)
        VRB_ST_WAIT_EN: begin
          ready_cnt <= '0;
          if (en_level) begin
            state <= VRB_ST_COUNT;
          end
        end
        VRB_ST_COUNT: begin
          if (!en_level) begin
            state <= VRB_ST_WAIT_EN;
          end else if (ready_cnt == CNT_W'(READY_CYCLES - 1)) begin
            state <= VRB_ST_READY;
          end else begin
            ready_cnt <= ready_cnt + 1'b1;
          end
        end
        VRB_ST_READY: begin
          if (!en_level) begin
            state <= VRB_ST_WAIT_EN;
          end
        end
        default: begin
          state <= VRB_ST_WAIT_EN;
        end
      endcase
    end
  end

  // Straps are caught on the first enabled edge after reset, never by the reset itself.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      boot_taken <= 1'b0;
      boot_voltage <= 8'h00;
      fast_slew_rate <= `VRB_FAST_SLEW_LOW;
    end else if (ce && !boot_taken) begin
      boot_taken <= 1'b1;
      boot_voltage <= boot_vid_strap;
      fast_slew_rate <= fast_rate_strap ? `VRB_FAST_SLEW_HIGH : `VRB_FAST_SLEW_LOW;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      current_vid_code <= 8'h00;
      vid_commanded <= 1'b0;
      slow_selected <= 1'b0;
    end else if (ce) begin
      if (!boot_taken) begin
        current_vid_code <= boot_vid_strap;
      end else if (vid_ok) begin
        current_vid_code <= cmd_data;
        vid_commanded <= 1'b1;
        slow_selected <= (cmd_type == VRB_CMD_SLOW_VID);
      end else if (vbyte_w) begin
        current_vid_code <= cmd_data;
        vid_commanded <= 1'b1;
      end
    end
  end

  // Only the writable registers are listed; read-only offsets simply have no write path.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      slow_rate_divider_select <= `VRB_RST_SLOW_DIV_SEL;
      max_vid_limit <= `VRB_RST_MAX_VID;
      power_state_setting <= `VRB_RST_POWER_STATE;
      vid_margin_steps <= `VRB_RST_MARGIN;
      multi_regulator_config <= `VRB_RST_MULTI_CFG;
      register_write_pointer <= `VRB_RST_WRITE_PTR;
      limit_point1_vid <= `VRB_RST_LIMIT;
      limit_point1_current <= `VRB_RST_LIMIT;
      limit_point2_vid <= `VRB_RST_LIMIT;
      limit_point2_current <= `VRB_RST_LIMIT;
      limit_point3_vid <= `VRB_RST_LIMIT;
      limit_point3_current <= `VRB_RST_LIMIT;
    end else if (ce) begin
      if (accepted && (cmd_type == VRB_CMD_SET_PS)) begin
        power_state_setting <= cmd_data;
      end
      if (ptr_wr) begin
        register_write_pointer <= cmd_data;
      end
      if (wr_en) begin
        case (register_write_pointer)
          `VRB_ADDR_SLOW_DIV_SEL: begin
            if (div_sel_legal) begin
              slow_rate_divider_select <= cmd_data;
            end
          end
          `VRB_ADDR_MAX_VID: max_vid_limit <= cmd_data;
          `VRB_ADDR_POWER_STATE: power_state_setting <= cmd_data;
          `VRB_ADDR_MARGIN: vid_margin_steps <= cmd_data;
          `VRB_ADDR_MULTI_CFG: multi_regulator_config <= cmd_data;
          `VRB_ADDR_WRITE_PTR: register_write_pointer <= cmd_data;
          `VRB_ADDR_P1_VID: limit_point1_vid <= cmd_data;
          `VRB_ADDR_P1_CUR: limit_point1_current <= cmd_data;
          `VRB_ADDR_P2_VID: limit_point2_vid <= cmd_data;
          `VRB_ADDR_P2_CUR: limit_point2_current <= cmd_data;
          `VRB_ADDR_P3_VID: limit_point3_vid <= cmd_data;
          `VRB_ADDR_P3_CUR: limit_point3_current <= cmd_data;
          default: begin
          end
        endcase
      end
    end
  end

  wire [3:0] div_shift = slow_rate_divider_select[3:0];
  wire [7:0] slow_slew_rate = fast_slew_rate >> div_shift;

  // Margin is sign-extended and the sum is clamped so a negative step never wraps.
  wire [8:0] margin_ext = {vid_margin_steps[`VRB_MARGIN_SIGN], vid_margin_steps};
  wire [8:0] vid_sum = {1'b0, current_vid_code} + margin_ext;
  wire neg_margin = vid_margin_steps[`VRB_MARGIN_SIGN];
  wire [7:0] margined_vid = (current_vid_code == 8'h00) ? 8'h00 :
                            (neg_margin && vid_sum[8]) ? 8'h00 :
                            (!neg_margin && vid_sum[8]) ? 8'hff : vid_sum[7:0];

  wire in_band1 = (current_vid_code <= limit_point1_vid) &&
                  (current_vid_code >= limit_point2_vid);
  wire in_band2 = (current_vid_code >= limit_point3_vid);
  wire [7:0] next_limit = in_band1 ? limit_point1_current :
                          in_band2 ? limit_point2_current : limit_point3_current;

  function automatic vrb_byte_t rd_select(input vrb_byte_t a);
    case (a)
      `VRB_ADDR_FAST_SLEW: rd_select = fast_slew_rate;
      `VRB_ADDR_SLOW_SLEW: rd_select = slow_slew_rate;
      `VRB_ADDR_BOOT_VOLTAGE: rd_select = boot_voltage;
      `VRB_ADDR_SLOW_DIV_SEL: rd_select = slow_rate_divider_select;
      `VRB_ADDR_DEEP_EXIT_LAT: rd_select = `VRB_VAL_DEEP_EXIT_LAT;
      `VRB_ADDR_LIGHT_EXIT_LAT: rd_select = `VRB_VAL_LIGHT_EXIT_LAT;
      `VRB_ADDR_EN_READY_LAT: rd_select = `VRB_VAL_EN_READY_LAT;
      `VRB_ADDR_PIN_MAX: rd_select = pin_max_value;
      `VRB_ADDR_INPUT_POWER_ALERT_THRESHOLD: rd_select = pin_alert_value;
      `VRB_ADDR_MAX_VID: rd_select = max_vid_limit;
      `VRB_ADDR_VID: rd_select = current_vid_code;
      `VRB_ADDR_POWER_STATE: rd_select = power_state_setting;
      `VRB_ADDR_MARGIN: rd_select = vid_margin_steps;
      `VRB_ADDR_MULTI_CFG: rd_select = multi_regulator_config;
      `VRB_ADDR_WRITE_PTR: rd_select = register_write_pointer;
      `VRB_ADDR_P1_VID: rd_select = limit_point1_vid;
      `VRB_ADDR_P1_CUR: rd_select = limit_point1_current;
      `VRB_ADDR_P2_VID: rd_select = limit_point2_vid;
      `VRB_ADDR_P2_CUR: rd_select = limit_point2_current;
      `VRB_ADDR_P3_VID: rd_select = limit_point3_vid;
      `VRB_ADDR_P3_CUR: rd_select = limit_point3_current;
      default: rd_select = 8'h00;
    endcase
  endfunction

  wire [7:0] rd_value = rd_select(cmd_addr);
  wire get_cmd = cmd_type == VRB_CMD_GET_REG;
  wire vrb_ack_e next_ack = !ready ? VRB_ACK_REJECT :
                            (is_vid_cmd && vid_too_high) ? VRB_ACK_NOT_SUPPORTED :
                            VRB_ACK_OK;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      resp_valid <= 1'b0;
      resp_ack <= VRB_ACK_OK;
      resp_data <= 8'h00;
    end else if (ce) begin
      resp_valid <= taken;
      if (taken) begin
        resp_ack <= next_ack;
        resp_data <= (ready && get_cmd) ? rd_value : 8'h00;
      end
    end
  end

  // A zero-volt command with the config bit set drops ready until a nonzero VID command or until ready is lost.
  logic ready_hold_low;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ready_hold_low <= 1'b0;
      regulator_ready_flag <= 1'b0;
      target_vid <= 8'h00;
      ramp_slew <= 8'h00;
      current_limit <= 8'h00;
      power_state_out <= 8'h00;
    end else if (ce) begin
      if (zero_drop) begin
        ready_hold_low <= 1'b1;
      end else if (vid_ok || !ready) begin
        ready_hold_low <= 1'b0;
      end
      regulator_ready_flag <= ready && !ready_hold_low && !zero_drop;
      target_vid <= margined_vid;
      ramp_slew <= slow_selected ? slow_slew_rate : fast_slew_rate;
      current_limit <= next_limit;
      power_state_out <= power_state_setting;
    end
  end

  // These checks are phrased from the rules, not from the logic above, so one slip cannot hide.
  AST_RESP_NEXT: assert property (@(posedge mclk) disable iff (!reset_n)
    (taken ##1 ce) |-> resp_valid) else $error("No answer after a command.");
  AST_REJECT: assert property (@(posedge mclk) disable iff (!reset_n)
    (taken && !ready) |=> resp_ack == VRB_ACK_REJECT && resp_data == 8'h00)
    else $error("Command before ready was not rejected.");
  AST_READY_FLAG: assert property (@(posedge mclk) disable iff (!reset_n)
    (regulator_ready_flag && $past(ce)) |-> $past(state == VRB_ST_READY))
    else $error("Ready flag high outside the ready state.");
  AST_ENABLE_DROP: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && !en_level ##1 ce) |=> !regulator_ready_flag)
    else $error("Ready flag stayed high without enable.");
  AST_MAX_VID: assert property (@(posedge mclk) disable iff (!reset_n)
    (accepted && is_vid_cmd && vid_too_high ##1 ce) |-> resp_ack == VRB_ACK_NOT_SUPPORTED)
    else $error("Over-limit VID was not refused.");
  AST_VID_OK_ACK: assert property (@(posedge mclk) disable iff (!reset_n)
    (accepted && is_vid_cmd && cmd_data <= max_vid_limit) |=> resp_ack == VRB_ACK_OK)
    else $error("Legal VID was not acknowledged.");
  AST_MAX_VID_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    (accepted && is_vid_cmd && vid_too_high) |=> $stable(current_vid_code))
    else $error("Over-limit VID changed the setting.");
  AST_VID_UPDATE: assert property (@(posedge mclk) disable iff (!reset_n)
    vid_ok |=> current_vid_code == $past(cmd_data)) else $error("VID not updated.");
  AST_SLOW_RATE: assert property (@(posedge mclk) disable iff (!reset_n)
    boot_taken |-> slow_rate_divider_select >= `VRB_DIV_SEL_MIN &&
    slow_rate_divider_select <= `VRB_DIV_SEL_MAX &&
    slow_slew_rate == (fast_slew_rate >> slow_rate_divider_select))
    else $error("Slow rate does not follow selector.");
  AST_DIV_IGNORE: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr_en && register_write_pointer == `VRB_ADDR_SLOW_DIV_SEL &&
    (cmd_data < `VRB_DIV_SEL_MIN || cmd_data > `VRB_DIV_SEL_MAX)) |=>
    $stable(slow_rate_divider_select)) else $error("Illegal divider select was stored.");
  AST_RO_FAST: assert property (@(posedge mclk) disable iff (!reset_n)
    (boot_taken && wr_en && register_write_pointer == `VRB_ADDR_FAST_SLEW) |=>
    $stable(fast_slew_rate)) else $error("Read-only register changed.");
  AST_BOOT_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    (boot_taken && !vid_commanded) |-> current_vid_code == boot_voltage)
    else $error("VID left boot voltage without a command.");
  AST_BOOT_RO: assert property (@(posedge mclk) disable iff (!reset_n)
    boot_taken |=> $stable(boot_voltage)) else $error("Boot voltage changed after startup.");
  AST_PTR_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    ptr_wr |=> register_write_pointer == $past(cmd_data)) else $error("Pointer not set.");
  AST_PS_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    (accepted && cmd_type == VRB_CMD_SET_PS) |=> power_state_setting == $past(cmd_data))
    else $error("Power state not stored.");
  AST_ZERO_DROP: assert property (@(posedge mclk) disable iff (!reset_n)
    (zero_drop ##1 ce) |-> !regulator_ready_flag ##1 (!ce || !regulator_ready_flag))
    else $error("Ready stayed high on zero VID.");
  AST_NO_MARGIN: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && vid_margin_steps == 8'h00) |=> target_vid == $past(current_vid_code))
    else $error("Zero margin altered the target.");
  AST_MARGIN_UP: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && current_vid_code != 8'h00 && !vid_margin_steps[`VRB_MARGIN_SIGN]) |=>
    target_vid >= $past(current_vid_code)) else $error("Positive margin lowered the target.");
  AST_MARGIN_DOWN: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && vid_margin_steps[`VRB_MARGIN_SIGN] && current_vid_code > ~vid_margin_steps) |=>
    target_vid == $past(8'(current_vid_code + vid_margin_steps)))
    else $error("Negative margin gave the wrong target.");
  AST_LIMIT_LOW: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && current_vid_code < limit_point3_vid && limit_point3_vid <= limit_point2_vid &&
    limit_point2_vid <= limit_point1_vid) |=> current_limit == $past(limit_point3_current))
    else $error("Lowest band did not give the last current.");

  COV_READY: cover property (@(posedge mclk) disable iff (!reset_n) $rose(regulator_ready_flag));
  COV_REFUSE: cover property (@(posedge mclk) disable iff (!reset_n)
    resp_valid && resp_ack == VRB_ACK_NOT_SUPPORTED);
  COV_SLOW: cover property (@(posedge mclk) disable iff (!reset_n)
    vid_ok && cmd_type == VRB_CMD_SLOW_VID);
  COV_NEG_MARGIN: cover property (@(posedge mclk) disable iff (!reset_n)
    neg_margin && current_vid_code != 8'h00);
  COV_ZERO_DROP: cover property (@(posedge mclk) disable iff (!reset_n)
    zero_drop);
endmodule
`default_nettype wire

// ---- dv/vrb_bus_master.sv ----
`timescale 1ns/1ns
`default_nettype none
module vrb_bus_master (
  input wire logic mclk,
  input wire logic resp_valid,
  input wire vrb_pkg::vrb_ack_e resp_ack,
  input wire vrb_pkg::vrb_byte_t resp_data,
  output logic cmd_valid,
  output vrb_pkg::vrb_cmd_e cmd_type,
  output vrb_pkg::vrb_byte_t cmd_addr,
  output vrb_pkg::vrb_byte_t cmd_data
);
  import vrb_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd_type = VRB_CMD_GET_REG;
    cmd_addr = 8'h00;
    cmd_data = 8'h00;
  end
  // Released address and data lines show the inverse of the last value, so a late sample cannot pass by luck.
  task automatic xfer(input vrb_cmd_e t, input vrb_byte_t a, input vrb_byte_t d,
                      input int idle, output vrb_ack_e ack, output vrb_byte_t q,
                      output logic hung);
    int n;
    hung = 1'b1;
    repeat (idle) @(negedge mclk);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_type = t;
    cmd_addr = a;
    cmd_data = d;
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd_addr = ~a;
    cmd_data = ~d;
    for (n = 0; n < 4 && hung; n++) begin
      if (resp_valid === 1'b1) begin
        ack = resp_ack;
        q = resp_data;
        hung = 1'b0;
      end else begin
        @(negedge mclk);
      end
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/vrb_register_bank_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end
module vrb_register_bank_tb;
  import vrb_pkg::*;
  logic mclk, reset_n, ce, enable_pin, fast_rate_strap, cmd_valid, resp_valid;
  logic regulator_ready_flag;
  vrb_byte_t boot_vid_strap, pin_max_value, pin_alert_value, cmd_addr, cmd_data;
  vrb_byte_t resp_data, target_vid, ramp_slew, current_limit, power_state_out, q;
  vrb_cmd_e cmd_type;
  vrb_ack_e resp_ack, ack;
  int failures = 0;
  int cmp_count = 0;
  vrb_register_bank #(.READY_CYCLES(8)) vrb_register_bank_i (
    .mclk(mclk), .reset_n(reset_n), .ce(ce), .enable_pin(enable_pin),
    .fast_rate_strap(fast_rate_strap), .boot_vid_strap(boot_vid_strap),
    .pin_max_value(pin_max_value), .pin_alert_value(pin_alert_value),
    .cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .resp_valid(resp_valid), .resp_ack(resp_ack), .resp_data(resp_data),
    .regulator_ready_flag(regulator_ready_flag), .target_vid(target_vid),
    .ramp_slew(ramp_slew), .current_limit(current_limit), .power_state_out(power_state_out)
  );
  vrb_bus_master vrb_bus_master_i (
    .mclk(mclk), .resp_valid(resp_valid), .resp_ack(resp_ack), .resp_data(resp_data),
    .cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_addr(cmd_addr), .cmd_data(cmd_data)
  );
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmd(input vrb_cmd_e t, input vrb_byte_t a, input vrb_byte_t d, input int idle);
    logic hung;
    vrb_bus_master_i.xfer(t, a, d, idle, ack, q, hung);
    if (hung !== 1'b0) begin
      failures++;
      give_verdict();
    end
  endtask
  task automatic rd(input vrb_byte_t a, input vrb_byte_t exp);
    cmd(VRB_CMD_GET_REG, a, 8'h00, 0);
    `CHK("read data", exp, q)
  endtask
  // The pointer is not auto-incremented, so every write carries its own address step.
  task automatic wr(input vrb_byte_t a, input vrb_byte_t d);
    cmd(VRB_CMD_SET_ADDR, 8'h00, a, 0);
    cmd(VRB_CMD_SET_DATA, 8'h00, d, 0);
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (regulator_ready_flag !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    // Four sync edges, one to start counting, eight counted, one to register the flag.
    `CHK("ready delay", 1'b1, n >= 13 && n <= 15)
    if (n >= 40) give_verdict();
  endtask
  task automatic t_startup();
    vrb_byte_t ra [20] = '{8'h24, 8'h25, 8'h26, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f,
      8'h30, 8'h32, 8'h33, 8'h34, 8'h35, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47};
    vrb_byte_t rv [20] = '{8'h0a, 8'h05, 8'h3c, 8'h01, 8'h8c, 8'h55, 8'hca, 8'h9a, 8'h71,
      8'hfb, 8'h00, 8'h00, 8'h00, 8'h35, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    cmd(VRB_CMD_FAST_VID, 8'h00, 8'h20, 0);
    `CHK("early ack", VRB_ACK_REJECT, ack)
    `CHK("boot target", 8'h3c, target_vid)
    enable_pin = 1'b1;
    wait_ready();
    foreach (ra[i]) begin
      cmd(VRB_CMD_GET_REG, ra[i], 8'h00, i % 3);
      `CHK("reset value", rv[i], q)
    end
    rd(8'h31, 8'h3c);
    `CHK("boot hold", 8'h3c, target_vid)
  endtask
  task automatic t_readonly();
    vrb_byte_t ra [4] = '{8'h24, 8'h26, 8'h2b, 8'h2d};
    vrb_byte_t rv [4] = '{8'h0a, 8'h3c, 8'h8c, 8'hca};
    foreach (ra[i]) begin
      wr(ra[i], 8'h77);
      rd(ra[i], rv[i]);
    end
  endtask
  task automatic t_divider();
    for (int n = 1; n <= 4; n++) begin
      wr(8'h2a, 8'(n));
      rd(8'h25, 8'h0a >> n);
      cmd(VRB_CMD_SLOW_VID, 8'h00, 8'h40, 0);
      @(negedge mclk);
      `CHK("slow ramp", 8'h0a >> n, ramp_slew)
    end
    wr(8'h2a, 8'h05);
    rd(8'h2a, 8'h04);
    cmd(VRB_CMD_FAST_VID, 8'h00, 8'h40, 0);
    @(negedge mclk);
    `CHK("fast ramp", 8'h0a, ramp_slew)
  endtask
  task automatic t_maxvid();
    cmd(VRB_CMD_FAST_VID, 8'h00, 8'hfc, 0);
    `CHK("over max ack", VRB_ACK_NOT_SUPPORTED, ack)
    rd(8'h31, 8'h40);
    cmd(VRB_CMD_FAST_VID, 8'h00, 8'hfb, 0);
    `CHK("at max ack", VRB_ACK_OK, ack)
    rd(8'h31, 8'hfb);
    wr(8'h30, 8'h60);
    cmd(VRB_CMD_SLOW_VID, 8'h00, 8'h61, 0);
    `CHK("new max ack", VRB_ACK_NOT_SUPPORTED, ack)
    cmd(VRB_CMD_SLOW_VID, 8'h00, 8'h60, 0);
    rd(8'h31, 8'h60);
    wr(8'h30, 8'hfb);
  endtask
  task automatic t_margin();
    vrb_byte_t m [4] = '{8'hff, 8'h01, 8'hfe, 8'h00};
    vrb_byte_t e [4] = '{8'h4f, 8'h51, 8'h4e, 8'h50};
    cmd(VRB_CMD_FAST_VID, 8'h00, 8'h50, 0);
    foreach (m[i]) begin
      wr(8'h33, m[i]);
      @(negedge mclk);
      `CHK("margined target", e[i], target_vid)
    end
    wr(8'h31, 8'h22);
    rd(8'h31, 8'h22);
  endtask
  task automatic t_limit();
    vrb_byte_t v [3] = '{8'h60, 8'h40, 8'h20};
    vrb_byte_t e [3] = '{8'h30, 8'h20, 8'h10};
    wr(8'h42, 8'h80);
    wr(8'h43, 8'h30);
    wr(8'h44, 8'h50);
    wr(8'h45, 8'h20);
    wr(8'h46, 8'h30);
    wr(8'h47, 8'h10);
    foreach (v[i]) begin
      cmd(VRB_CMD_FAST_VID, 8'h00, v[i], 1);
      @(negedge mclk);
      `CHK("current limit", e[i], current_limit)
    end
  endtask
  task automatic t_state();
    cmd(VRB_CMD_SET_PS, 8'h00, 8'h03, 0);
    rd(8'h32, 8'h03);
    `CHK("state out", 8'h03, power_state_out)
    wr(8'h34, 8'h01);
    rd(8'h35, 8'h34);
    cmd(VRB_CMD_FAST_VID, 8'h00, 8'h00, 0);
    @(negedge mclk);
    `CHK("zero vid ready", 1'b0, regulator_ready_flag)
    `CHK("zero vid target", 8'h00, target_vid)
    enable_pin = 1'b0;
    repeat (8) @(negedge mclk);
    enable_pin = 1'b1;
    wait_ready();
  endtask
  // A frozen clock enable must hold ready even with enable gone; then reset with the high strap.
  task automatic t_restart();
    ce = 1'b0;
    enable_pin = 1'b0;
    repeat (10) @(negedge mclk);
    `CHK("frozen ready", 1'b1, regulator_ready_flag)
    enable_pin = 1'b1;
    ce = 1'b1;
    @(negedge mclk);
    reset_n = 1'b0;
    fast_rate_strap = 1'b1;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    wait_ready();
    rd(8'h24, 8'h1e);
    rd(8'h25, 8'h0f);
    rd(8'h32, 8'h00);
    rd(8'h31, 8'h3c);
  endtask
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    enable_pin = 1'b0;
    fast_rate_strap = 1'b0;
    boot_vid_strap = 8'h3c;
    pin_max_value = 8'h9a;
    pin_alert_value = 8'h71;
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    t_startup();
    t_readonly();
    t_divider();
    t_maxvid();
    t_margin();
    t_limit();
    t_state();
    t_restart();
    give_verdict();
  end
endmodule
`default_nettype wire
